// File: verilog/reset_source_map.svh
`ifndef RESET_SOURCE_MAP_SVH
`define RESET_SOURCE_MAP_SVH

// register byte offsets
`define RSF_ADDR_FLAGS 12'h000
`define RSF_ADDR_PIN_SEL 12'h004
`define RSF_ADDR_LEVEL_SEL 12'h008
`define RSF_ADDR_FLASH_CTRL 12'h00c
`define RSF_ADDR_CORE_STATUS 12'h010
`define RSF_ADDR_IRQ_STATUS 12'h014
`define RSF_ADDR_IRQ_MASK 12'h018

// reset-cause flag bit positions
`define RSF_BIT_WDOG_CFG 0
`define RSF_BIT_LEVEL 1
`define RSF_BIT_BROWNOUT 2
`define RSF_BIT_PIN_SEL 3

// interrupt status bit positions
`define RSF_IRQ_PIN_SEL 0
`define RSF_IRQ_LEVEL 1
`define RSF_IRQ_BROWNOUT 2
`define RSF_IRQ_FLASH 3
`define RSF_IRQ_WDOG 4
`define RSF_IRQ_PIN_RESET 5
`define RSF_IRQ_WDOG_CFG 6
`define RSF_IRQ_WIDTH 7

// codes and reset values
`define RSF_PIN_SEL_GPIO 8'h55
`define RSF_PIN_SEL_RESET 8'haa
`define RSF_LEVEL_POR 8'h66
`define RSF_LEVEL_1 8'h55
`define RSF_LEVEL_2 8'h33
`define RSF_LEVEL_3 8'h99
`define RSF_LEVEL_4 8'haa
`define RSF_LEVEL_OFF 8'hf0
`define RSF_FLASH_POR 8'h00
`define RSF_FLASH_RESET_KEY 8'h55

// timing
`define RSF_CLK_MHZ 10
`define RSF_SRESET_NS 1000
`define RSF_SRESET_CYCLES ((`RSF_SRESET_NS * `RSF_CLK_MHZ + 999) / 1000)
`define RSF_LVR_MIN_NS 1200
`define RSF_LVR_CYCLES ((`RSF_LVR_MIN_NS * `RSF_CLK_MHZ + 999) / 1000)
`define RSF_HOLD_CYCLES 16
`define RSF_WDOG_CYCLES 8192

`endif

// File: verilog/reset_source_pkg.sv
`default_nettype none
package reset_source_pkg;
    // core operating mode reported by the core
    typedef enum logic [1:0] {mode_fast, mode_slow, mode_idle, mode_sleep} power_mode_t;
    // reset sequencer states
    typedef enum logic [1:0] {seq_run, seq_cold, seq_warm} seq_t;
endpackage
`default_nettype wire

// File: verilog/reset_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module reset_delay_timer #(
    parameter logic [15:0] LIMIT = 16'h0010
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic clear,
    output logic done
);
    logic [15:0] count;
    logic fired;
    logic at_limit;

    // last cycle of a continuous run of LIMIT cycles
    assign at_limit = (count == LIMIT - 16'h0001);

    // counts while run holds; fires once until run drops or clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
            fired <= 1'b0;
        end else if (clear || !run) begin
            count <= 16'h0000;
            fired <= 1'b0;
        end else if (!fired) begin
            if (at_limit) begin
                fired <= 1'b1;
            end else begin
                count <= count + 16'h0001;
            end
        end
    end

    // one-cycle pulse on expiry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
        end else begin
            done <= run && !clear && !fired && at_limit;
        end
    end
endmodule
`default_nettype wire

// File: verilog/reset_source_flags.sv
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_map.svh"
module reset_source_flags #(
    parameter logic [15:0] WDOG_TIMEOUT_CYCLES = 16'(`RSF_WDOG_CYCLES)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire reset_source_pkg::power_mode_t power_mode,
    input wire logic low_voltage_pin,
    input wire logic reset_pin_n,
    input wire logic wdog_clear,
    input wire logic wdog_config_fault,
    output logic irq,
    output logic device_reset,
    output logic pc_zero,
    output logic sp_clear,
    output logic sp_top,
    output logic irq_disable_all,
    output logic timers_off,
    output logic ports_input
);
    localparam logic [15:0] SRESET_CYCLES = 16'(`RSF_SRESET_CYCLES);
    localparam logic [15:0] LVR_CYCLES = 16'(`RSF_LVR_CYCLES);
    localparam logic [7:0] HOLD_CYCLES = 8'(`RSF_HOLD_CYCLES);

    reset_source_pkg::seq_t state;
    logic [7:0] hold_count;
    logic [3:0] cause_flags;
    logic [7:0] reset_pin_select;
    logic [7:0] brownout_level_select;
    logic [7:0] flash_ctrl_second;
    logic watchdog_expiry_flag;
    logic powerdown_flag;
    logic [7:0] timebase;
    logic [`RSF_IRQ_WIDTH-1:0] irq_status;
    logic [`RSF_IRQ_WIDTH-1:0] irq_mask;
    logic bo_meta;
    logic bo_sync;
    logic pin_meta;
    logic pin_sync;
    logic flash_reset;
    logic wr_en;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic run_mode;
    logic pin_sel_bad;
    logic level_bad;
    logic bo_run;
    logic bo_done;
    logic sel_done;
    logic lvl_done;
    logic wdog_done;
    logic pin_reset;
    logic wdog_cold;
    logic warm_req;
    logic cold_req;
    logic in_cold;
    logic [3:0] flag_set;
    logic [`RSF_IRQ_WIDTH-1:0] irq_set;

    // two-stage synchronisers for the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bo_meta <= 1'b0;
            bo_sync <= 1'b0;
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            bo_meta <= low_voltage_pin;
            bo_sync <= bo_meta;
            pin_meta <= reset_pin_n;
            pin_sync <= pin_meta;
        end
    end

    // code checks and mode decode
    assign run_mode = (power_mode == reset_source_pkg::mode_fast) ||
                      (power_mode == reset_source_pkg::mode_slow);
    assign pin_sel_bad = (reset_pin_select != `RSF_PIN_SEL_GPIO) &&
                         (reset_pin_select != `RSF_PIN_SEL_RESET);
    assign level_bad = (brownout_level_select != `RSF_LEVEL_POR) &&
                       (brownout_level_select != `RSF_LEVEL_1) &&
                       (brownout_level_select != `RSF_LEVEL_2) &&
                       (brownout_level_select != `RSF_LEVEL_3) &&
                       (brownout_level_select != `RSF_LEVEL_4) &&
                       (brownout_level_select != `RSF_LEVEL_OFF);
    // monitor is off in idle/sleep and when disabled
    assign bo_run = bo_sync && run_mode && !level_bad &&
                    (brownout_level_select != `RSF_LEVEL_OFF);
    assign in_cold = (state == reset_source_pkg::seq_cold);

    // software-reset delay for a corrupt pin-select code
    reset_delay_timer #(.LIMIT(SRESET_CYCLES)) u_sel_delay (
        .pclk(pclk),
        .presetn(presetn),
        .run(pin_sel_bad),
        .clear(1'b0),
        .done(sel_done)
    );

    // software-reset delay for a corrupt level code
    reset_delay_timer #(.LIMIT(SRESET_CYCLES)) u_lvl_delay (
        .pclk(pclk),
        .presetn(presetn),
        .run(level_bad),
        .clear(1'b0),
        .done(lvl_done)
    );

    // low voltage must persist before it counts
    reset_delay_timer #(.LIMIT(LVR_CYCLES)) u_bo_filter (
        .pclk(pclk),
        .presetn(presetn),
        .run(bo_run),
        .clear(1'b0),
        .done(bo_done)
    );

    // watchdog restarts after every reset and counts at once
    reset_delay_timer #(.LIMIT(WDOG_TIMEOUT_CYCLES)) u_watchdog (
        .pclk(pclk),
        .presetn(presetn),
        .run(1'b1),
        .clear(wdog_clear || in_cold || (state == reset_source_pkg::seq_warm)),
        .done(wdog_done)
    );

    // reset requests
    assign pin_reset = !pin_sync && (reset_pin_select == `RSF_PIN_SEL_RESET);
    assign wdog_cold = wdog_done && run_mode;
    assign warm_req = wdog_done && !run_mode;
    assign cold_req = pin_reset || bo_done || lvl_done || sel_done ||
                      flash_reset || wdog_config_fault || wdog_cold;

    // reset sequencer: cold holds the device, warm is one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= reset_source_pkg::seq_cold;
            hold_count <= HOLD_CYCLES;
        end else begin
            case (state)
                reset_source_pkg::seq_run: begin
                    if (cold_req) begin
                        state <= reset_source_pkg::seq_cold;
                        hold_count <= HOLD_CYCLES;
                    end else if (warm_req) begin
                        state <= reset_source_pkg::seq_warm;
                    end
                end
                reset_source_pkg::seq_cold: begin
                    if (cold_req) begin
                        hold_count <= HOLD_CYCLES;
                    end else if (hold_count == 8'h01) begin
                        state <= reset_source_pkg::seq_run;
                    end else begin
                        hold_count <= hold_count - 8'h01;
                    end
                end
                reset_source_pkg::seq_warm: begin
                    state <= cold_req ? reset_source_pkg::seq_cold : reset_source_pkg::seq_run;
                    hold_count <= HOLD_CYCLES;
                end
                default: begin
                    state <= reset_source_pkg::seq_cold;
                end
            endcase
        end
    end

    // reset outputs to the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_reset <= 1'b1;
            pc_zero <= 1'b1;
            sp_clear <= 1'b0;
            sp_top <= 1'b1;
            irq_disable_all <= 1'b1;
            timers_off <= 1'b1;
            ports_input <= 1'b1;
        end else begin
            device_reset <= in_cold || cold_req;
            pc_zero <= in_cold || cold_req || warm_req;
            sp_clear <= warm_req && !cold_req && !in_cold;
            sp_top <= in_cold || cold_req;
            irq_disable_all <= in_cold || cold_req;
            timers_off <= in_cold || cold_req;
            ports_input <= in_cold || cold_req;
        end
    end

    // time base counter, cleared by every device reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timebase <= 8'h00;
        end else if (in_cold) begin
            timebase <= 8'h00;
        end else begin
            timebase <= timebase + 8'h01;
        end
    end

    // apb strobe: writes land at the completing access edge
    assign wr_en = psel && penable && pready && pwrite;

    // cause flag sets
    assign flag_set[`RSF_BIT_WDOG_CFG] = wdog_config_fault;
    assign flag_set[`RSF_BIT_LEVEL] = lvl_done;
    assign flag_set[`RSF_BIT_BROWNOUT] = bo_done;
    assign flag_set[`RSF_BIT_PIN_SEL] = sel_done;

    // sticky cause flags; writing zero clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_flags <= 4'h0;
        end else if (wr_en && paddr == `RSF_ADDR_FLAGS) begin
            cause_flags <= (cause_flags & pwdata[3:0]) | flag_set;
        end else begin
            cause_flags <= cause_flags | flag_set;
        end
    end

    // expiry and powerdown flags, cleared only at power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_expiry_flag <= 1'b0;
            powerdown_flag <= 1'b0;
        end else begin
            if (wdog_done) begin
                watchdog_expiry_flag <= 1'b1;
            end
            if (warm_req) begin
                powerdown_flag <= 1'b1;
            end
        end
    end

    // pin-select register, back to gpio on every cold reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_pin_select <= `RSF_PIN_SEL_GPIO;
        end else if (cold_req) begin
            reset_pin_select <= `RSF_PIN_SEL_GPIO;
        end else if (wr_en && paddr == `RSF_ADDR_PIN_SEL) begin
            reset_pin_select <= pwdata[7:0];
        end
    end

    // level register survives a brownout or warm reset, reverts on any other cold reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_level_select <= `RSF_LEVEL_POR;
        end else if (lvl_done || (cold_req && !bo_done)) begin
            brownout_level_select <= `RSF_LEVEL_POR;
        end else if (wr_en && paddr == `RSF_ADDR_LEVEL_SEL) begin
            brownout_level_select <= pwdata[7:0];
        end
    end

    // flash control: the key value fires a whole-device reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_ctrl_second <= `RSF_FLASH_POR;
            flash_reset <= 1'b0;
        end else begin
            flash_reset <= wr_en && (paddr == `RSF_ADDR_FLASH_CTRL) &&
                           (pwdata[7:0] == `RSF_FLASH_RESET_KEY);
            if (cold_req) begin
                flash_ctrl_second <= `RSF_FLASH_POR;
            end else if (wr_en && paddr == `RSF_ADDR_FLASH_CTRL) begin
                flash_ctrl_second <= pwdata[7:0];
            end
        end
    end

    // interrupt events, one per reset cause
    assign irq_set[`RSF_IRQ_PIN_SEL] = sel_done;
    assign irq_set[`RSF_IRQ_LEVEL] = lvl_done;
    assign irq_set[`RSF_IRQ_BROWNOUT] = bo_done;
    assign irq_set[`RSF_IRQ_FLASH] = flash_reset;
    assign irq_set[`RSF_IRQ_WDOG] = wdog_done;
    assign irq_set[`RSF_IRQ_PIN_RESET] = pin_reset && !in_cold;
    assign irq_set[`RSF_IRQ_WDOG_CFG] = wdog_config_fault;

    // sticky status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (wr_en && paddr == `RSF_ADDR_IRQ_STATUS) begin
            irq_status <= (irq_status & ~pwdata[`RSF_IRQ_WIDTH-1:0]) | irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_en && paddr == `RSF_ADDR_IRQ_MASK) begin
            irq_mask <= pwdata[`RSF_IRQ_WIDTH-1:0];
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // read mux and error decode
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (paddr == `RSF_ADDR_FLAGS) begin
            next_prdata = {28'h0000000, cause_flags};
        end else if (paddr == `RSF_ADDR_PIN_SEL) begin
            next_prdata = {24'h000000, reset_pin_select};
        end else if (paddr == `RSF_ADDR_LEVEL_SEL) begin
            next_prdata = {24'h000000, brownout_level_select};
        end else if (paddr == `RSF_ADDR_FLASH_CTRL) begin
            next_prdata = {24'h000000, flash_ctrl_second};
        end else if (paddr == `RSF_ADDR_CORE_STATUS) begin
            next_prdata = {16'h0000, timebase, 6'h00, powerdown_flag, watchdog_expiry_flag};
        end else if (paddr == `RSF_ADDR_IRQ_STATUS) begin
            next_prdata = {25'h0000000, irq_status};
        end else if (paddr == `RSF_ADDR_IRQ_MASK) begin
            next_prdata = {25'h0000000, irq_mask};
        end else begin
            next_pslverr = 1'b1;
        end
    end

    // apb answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= next_pslverr;
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: test/reset_source_flags_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_map.svh"
module reset_source_flags_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic irq,
    input wire logic device_reset,
    input wire logic pc_zero,
    input wire logic sp_clear,
    input wire logic sp_top,
    input wire logic irq_disable_all,
    input wire logic timers_off,
    input wire logic ports_input
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    // completed bus access
    assign acc = psel && penable && pready;
    a_flags_upper_zero: assert property (
        acc && !pwrite && paddr == `RSF_ADDR_FLAGS |-> prdata[31:4] == 28'h0)
        else $error("cause flag read shows upper bits");
    a_flash_key_reset: assert property (
        acc && pwrite && paddr == `RSF_ADDR_FLASH_CTRL && pwdata[7:0] == `RSF_FLASH_RESET_KEY
        |-> ##[1:3] device_reset)
        else $error("flash key write gave no device reset");
    a_cold_irq_off: assert property (device_reset |-> irq_disable_all && pc_zero)
        else $error("cold reset without interrupt disable or pc zero");
    a_cold_timers_off: assert property (device_reset |-> timers_off)
        else $error("cold reset without timers off");
    a_cold_ports_in: assert property (device_reset |-> ports_input)
        else $error("cold reset without ports as inputs");
    a_cold_stack_top: assert property (device_reset |-> sp_top)
        else $error("cold reset without stack top");
    a_warm_keeps_state: assert property (sp_clear |-> pc_zero && !device_reset)
        else $error("warm reset mismatch");
    a_warm_single_pulse: assert property ($rose(sp_clear) |=> !sp_clear)
        else $error("stack clear longer than one cycle");
    // main scenarios reached
    cover property ($fell(device_reset));
    cover property (sp_clear);
    cover property ($rose(irq));
endmodule
bind reset_source_flags reset_source_flags_chk reset_source_flags_chk_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .irq, .device_reset,
    .pc_zero, .sp_clear, .sp_top, .irq_disable_all, .timers_off, .ports_input);
`default_nettype wire

// File: test/reset_source_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_map.svh"
module reset_source_flags_tb;
    logic pclk, presetn, psel, penable, pwrite, low_voltage_pin, reset_pin_n;
    logic wdog_clear, wdog_config_fault, pready, pslverr, irq, device_reset, pc_zero;
    logic sp_clear, sp_top, irq_disable_all, timers_off, ports_input, errv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    reset_source_pkg::power_mode_t power_mode;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int k;
    reset_source_flags #(.WDOG_TIMEOUT_CYCLES(16'h0040)) reset_source_flags_i (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .power_mode, .low_voltage_pin, .reset_pin_n, .wdog_clear, .wdog_config_fault, .irq,
        .device_reset, .pc_zero, .sp_clear, .sp_top, .irq_disable_all, .timers_off,
        .ports_input);
    // free-running 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rdv & m, e);
    endtask
    task automatic wait_dr(input logic v);
        for (int i = 0; i < 300 && device_reset !== v; i++) @(posedge pclk);
        check({31'h0, device_reset}, {31'h0, v});
    endtask
    task automatic cold();
        wait_dr(1'b1);
        wait_dr(1'b0);
    endtask
    // main sequence
    initial begin
        {psel, penable, pwrite, low_voltage_pin, wdog_config_fault} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        reset_pin_n = 1'b1;
        wdog_clear = 1'b1;
        power_mode = reset_source_pkg::mode_fast;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({26'h0, device_reset, pc_zero, irq_disable_all, timers_off, ports_input,
            sp_top}, 32'h3f);
        rd(`RSF_ADDR_FLAGS, 32'hffffffff, 32'h0);
        rd(`RSF_ADDR_CORE_STATUS, 32'h3, 32'h0);
        rd(`RSF_ADDR_PIN_SEL, 32'hff, 32'h55);
        rd(`RSF_ADDR_LEVEL_SEL, 32'hff, 32'h66);
        wait_dr(1'b0);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, errv}, 32'h1);
        check(rdv, 32'h0);
        // undefined level code, then interrupt mask and clear
        apb(1'b1, `RSF_ADDR_IRQ_MASK, 32'h7f);
        apb(1'b1, `RSF_ADDR_LEVEL_SEL, 32'h12);
        cold();
        rd(`RSF_ADDR_FLAGS, 32'hff, 32'h2);
        rd(`RSF_ADDR_LEVEL_SEL, 32'hff, 32'h66);
        rd(`RSF_ADDR_IRQ_STATUS, 32'h7f, 32'h1 << `RSF_IRQ_LEVEL);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, `RSF_ADDR_IRQ_MASK, 32'h0);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, `RSF_ADDR_IRQ_MASK, 32'h7f);
        apb(1'b1, `RSF_ADDR_IRQ_STATUS, 32'h7f);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        // corrupt pin select code
        apb(1'b1, `RSF_ADDR_PIN_SEL, 32'h3c);
        cold();
        rd(`RSF_ADDR_FLAGS, 32'hff, 32'ha);
        rd(`RSF_ADDR_PIN_SEL, 32'hff, 32'h55);
        apb(1'b1, `RSF_ADDR_FLAGS, 32'h8);
        rd(`RSF_ADDR_FLAGS, 32'hff, 32'h8);
        apb(1'b1, `RSF_ADDR_FLAGS, 32'h0);
        rd(`RSF_ADDR_FLAGS, 32'hff, 32'h0);
        // brownout keeps level code and status flags
        apb(1'b1, `RSF_ADDR_LEVEL_SEL, 32'h33);
        low_voltage_pin <= 1'b1;
        wait_dr(1'b1);
        low_voltage_pin <= 1'b0;
        wait_dr(1'b0);
        rd(`RSF_ADDR_FLAGS, 32'hff, 32'h4);
        rd(`RSF_ADDR_LEVEL_SEL, 32'hff, 32'h33);
        rd(`RSF_ADDR_CORE_STATUS, 32'h3, 32'h0);
        apb(1'b1, `RSF_ADDR_FLASH_CTRL, 32'h55);
        cold();
        rd(`RSF_ADDR_CORE_STATUS, 32'hff00, 32'h0300);
        rd(`RSF_ADDR_FLAGS, 32'hff, 32'h4);
        // watchdog expiry in slow mode
        power_mode <= reset_source_pkg::mode_slow;
        wdog_clear <= 1'b0;
        wait_dr(1'b1);
        wdog_clear <= 1'b1;
        wait_dr(1'b0);
        rd(`RSF_ADDR_CORE_STATUS, 32'h3, 32'h1);
        // watchdog expiry in sleep
        power_mode <= reset_source_pkg::mode_sleep;
        wdog_clear <= 1'b0;
        for (k = 0; k < 300 && sp_clear !== 1'b1; k++) @(posedge pclk);
        check({29'h0, sp_clear, pc_zero, device_reset}, 32'h6);
        // second watchdog expiry, now in idle
        power_mode <= reset_source_pkg::mode_idle;
        @(posedge pclk);
        for (k = 0; k < 300 && sp_clear !== 1'b1; k++) @(posedge pclk);
        check({29'h0, sp_clear, pc_zero, device_reset}, 32'h6);
        wdog_clear <= 1'b1;
        power_mode <= reset_source_pkg::mode_fast;
        rd(`RSF_ADDR_CORE_STATUS, 32'h3, 32'h3);
        // reset pin in fast mode
        apb(1'b1, `RSF_ADDR_PIN_SEL, 32'haa);
        reset_pin_n <= 1'b0;
        wait_dr(1'b1);
        reset_pin_n <= 1'b1;
        wait_dr(1'b0);
        rd(`RSF_ADDR_CORE_STATUS, 32'h3, 32'h3);
        wdog_config_fault <= 1'b1;
        @(posedge pclk);
        wdog_config_fault <= 1'b0;
        cold();
        rd(`RSF_ADDR_FLAGS, 32'hff, 32'h5);
        // config fault on the same edge as a flag clear: the set wins
        fork
            apb(1'b1, `RSF_ADDR_FLAGS, 32'h0);
            begin
                repeat (2) @(posedge pclk);
                wdog_config_fault <= 1'b1;
                @(posedge pclk);
                wdog_config_fault <= 1'b0;
            end
        join
        cold();
        rd(`RSF_ADDR_FLAGS, 32'hff, 32'h1);
        // second power-on reset mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`RSF_ADDR_CORE_STATUS, 32'h3, 32'h0);
        rd(`RSF_ADDR_FLAGS, 32'hff, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
